// ===== design/mieg_gate.v
// Metering interrupt enable registers, status flags and pending interrupt
`timescale 1ns/1ps
`default_nettype none
`include "mieg_consts.vh"

module mieg_gate
(
    input  wire       i_clk,
    input  wire       i_resetn,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    input  wire [5:0] i_evt_low,
    input  wire [7:0] i_evt_mid,
    input  wire [5:0] i_evt_high,
    output reg  [7:0] o_rdata,
    output reg        o_irq_pending
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0] en_low_r;
    reg  [7:0] en_mid_r;
    reg  [7:0] en_high_r;
    reg  [5:0] st_low_r;
    reg  [7:0] st_mid_r;
    reg  [5:0] st_high_r;
    wire [5:0] st_low_nxt;
    wire [7:0] st_mid_nxt;
    wire [5:0] st_high_nxt;
    reg  [7:0] rdata_nxt;
    wire       any_low;
    wire       any_mid;
    wire       any_high;
    wire       pend_nxt;
    wire       wr_en_low;
    wire       wr_en_mid;
    wire       wr_en_high;
    wire       wr_st_low;
    wire       wr_st_mid;
    wire       wr_st_high;
    wire [5:0] hit_low;
    wire [7:0] hit_mid;
    wire [5:0] hit_high;
    wire [7:0] st_low_view;
    wire [7:0] st_high_view;
    genvar     gi;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Strobe qualified address match, shared by every write target
    function addr_hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    // One flag bit; the event is ORed in after the clear, so a
    // clear landing with a fresh event cannot lose that event
    function flag_next;
        input cur;
        input evt;
        input clr;
        begin
            flag_next = evt | (cur & ~clr);
        end
    endfunction

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wr_en_low  = addr_hit(i_wr, i_addr, `MIEG_ADDR_EN_LOW);
    assign wr_en_mid  = addr_hit(i_wr, i_addr, `MIEG_ADDR_EN_MID);
    assign wr_en_high = addr_hit(i_wr, i_addr, `MIEG_ADDR_EN_HIGH);
    assign wr_st_low  = addr_hit(i_wr, i_addr, `MIEG_ADDR_ST_LOW);
    assign wr_st_mid  = addr_hit(i_wr, i_addr, `MIEG_ADDR_ST_MID);
    assign wr_st_high = addr_hit(i_wr, i_addr, `MIEG_ADDR_ST_HIGH);

    // ------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------
    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            en_low_r  <= `MIEG_EN_RESET;
            en_mid_r  <= `MIEG_EN_RESET;
            en_high_r <= `MIEG_EN_RESET;
        end
        else
        begin
            // Write lands at the taken edge; pending follows next edge
            if (wr_en_low)
                en_low_r <= i_wdata & `MIEG_EN_LOW_MASK;
            if (wr_en_mid)
                en_mid_r <= i_wdata & `MIEG_EN_MID_MASK;
            if (wr_en_high)
                en_high_r <= i_wdata & `MIEG_EN_HIGH_MASK;
        end
    end

    // ------------------------------------------------------------
    // Status flags: write one to clear, a new event wins
    // ------------------------------------------------------------
    // Pulse events set their flags regardless of the enable bits
    generate
        for (gi = 0; gi < 6; gi = gi + 1)
        begin : g_st_low
            assign st_low_nxt[gi] = flag_next(st_low_r[gi],
                i_evt_low[gi], wr_st_low & i_wdata[gi]);
        end

        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_st_mid
            assign st_mid_nxt[gi] = flag_next(st_mid_r[gi],
                i_evt_mid[gi], wr_st_mid & i_wdata[gi]);
        end

        for (gi = 0; gi < 6; gi = gi + 1)
        begin : g_st_high
            assign st_high_nxt[gi] = flag_next(st_high_r[gi],
                i_evt_high[gi], wr_st_high & i_wdata[gi]);
        end
    endgenerate

    // Flags clear only by software or by reset
    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            st_low_r <= 6'h00;
        else
            st_low_r <= st_low_nxt;
    end

    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            st_mid_r <= 8'h00;
        else
            st_mid_r <= st_mid_nxt;
    end

    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            st_high_r <= 6'h00;
        else
            st_high_r <= st_high_nxt;
    end

    // ------------------------------------------------------------
    // Gating; computed on next state so summary and read agree
    // ------------------------------------------------------------
    // Flags are stored even while masked, so enabling later still
    // raises the request for an event that came before
    assign hit_low  = st_low_nxt & en_low_r[5:0];
    assign hit_mid  = st_mid_nxt & en_mid_r;
    assign hit_high = st_high_nxt & en_high_r[5:0];
    assign any_low  = |hit_low;
    assign any_mid  = |hit_mid;
    assign any_high = |hit_high;
    assign pend_nxt = any_low | any_mid | any_high;

    // Registered so the core sees a glitch-free level, at the
    // cost of one cycle of latency

    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_irq_pending <= 1'b0;
        else
            o_irq_pending <= pend_nxt;
    end

    // ------------------------------------------------------------
    // Read port, registered
    // ------------------------------------------------------------
    // Unused status bits read zero; the summary bit is the
    // registered request, so a read returns the pin level sampled at the read edge
    assign st_low_view  = {o_irq_pending, 1'h0, st_low_r};
    assign st_high_view = {2'h0, st_high_r};

    always @*
    begin
        case (i_addr)
            `MIEG_ADDR_EN_LOW:  rdata_nxt = en_low_r;
            `MIEG_ADDR_EN_MID:  rdata_nxt = en_mid_r;
            `MIEG_ADDR_EN_HIGH: rdata_nxt = en_high_r;
            `MIEG_ADDR_ST_LOW:  rdata_nxt = st_low_view;
            `MIEG_ADDR_ST_MID:  rdata_nxt = st_mid_r;
            `MIEG_ADDR_ST_HIGH: rdata_nxt = st_high_view;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= rdata_nxt;
    end

endmodule // mieg_gate
`default_nettype wire

// ===== pkg/mieg_consts.vh
// Constants for the metering interrupt enable gate
`ifndef MIEG_CONSTS_VH
`define MIEG_CONSTS_VH
`define MIEG_ADDR_EN_LOW   8'hD9
`define MIEG_ADDR_EN_MID   8'hDA
`define MIEG_ADDR_EN_HIGH  8'hDB
`define MIEG_ADDR_ST_LOW   8'hDC
`define MIEG_ADDR_ST_MID   8'hDD
`define MIEG_ADDR_ST_HIGH  8'hDE
`define MIEG_EN_LOW_MASK   8'h3F
`define MIEG_EN_MID_MASK   8'hFF
`define MIEG_EN_HIGH_MASK  8'h3F
`define MIEG_EN_RESET      8'h00
`define MIEG_SUMMARY_BIT   7
`define MIEG_FAULT_BIT     5
`define MIEG_ACT_NL_BIT    0
`define MIEG_PULSE2_BIT    7
`define MIEG_PULSE1_BIT    6
`define MIEG_APP_OVF_BIT   5
`define MIEG_WAVE_BIT      5
`define MIEG_ZX_BIT        0
`endif

// ===== verif/mieg_sva.sv
// Port assertions for the interrupt gate
`timescale 1ns/1ps
`default_nettype none
module mieg_sva(input wire logic i_clk,i_resetn,i_wr,i_rd,o_irq_pending,
input wire logic [7:0] i_addr,i_wdata,i_evt_mid,o_rdata,
input wire logic [5:0] i_evt_low,i_evt_high);
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_resetn);
AST_RST: assert property ($rose(i_resetn) |-> !o_irq_pending)
else $error("pending at reset");
AST_UNM: assert property (i_rd&&i_addr==8'h00 |=> o_rdata==8'h00)
else $error("unmapped");
AST_RSL: assert property (i_rd&&i_addr==8'hD9 |=> !o_rdata[7:6])
else $error("reserved low");
AST_RSH: assert property (i_rd&&i_addr==8'hDB |=> !o_rdata[7:6])
else $error("reserved high");
AST_MID: assert property (i_wr&&i_addr==8'hDA ##1 i_rd&&i_addr==8'hDA
|=> o_rdata==$past(i_wdata,2)) else $error("readback");
AST_SUM: assert property (i_rd&&i_addr==8'hDC |=>
o_rdata[7]==$past(o_irq_pending)) else $error("summary");
AST_RISE: assert property ($rose(o_irq_pending) |->
$past(i_wr||(|{i_evt_low,i_evt_mid,i_evt_high})) || $past(i_wr,2))
else $error("rise");
AST_FALL: assert property ($fell(o_irq_pending) |->
$past(i_wr) || $past(i_wr,2)) else $error("fall");
cover property ($rose(o_irq_pending));
cover property ($fell(o_irq_pending));
cover property (i_rd&&i_addr==8'hDC);
endmodule // mieg_sva
`default_nettype wire

// ===== verif/mieg_core.sv
// Core interrupt input model
`timescale 1ns/1ps
`default_nettype none
module mieg_core(input wire logic i_clk,i_irq,output logic o_taken);
// Level input: request seen until the flag is cleared
always @(posedge i_clk) o_taken <= i_irq;
endmodule // mieg_core
`default_nettype wire

// ===== verif/mieg_gate_tb.sv
// Self-checking bench for the interrupt gate
`timescale 1ns/1ps
`default_nettype none
module mieg_gate_tb;
logic i_clk=0,i_resetn=0,i_wr=0,i_rd=0,o_irq_pending,taken;
logic [7:0] i_addr=0,i_wdata=0,i_evt_mid=0,o_rdata,a,m;
logic [5:0] i_evt_low=0,i_evt_high=0;
logic [39:0] mt=40'h8020402001;
int fail_count=0,n_checks=0;
always #12.5 i_clk=~i_clk;
mieg_gate u_dut(.i_clk(i_clk),.i_resetn(i_resetn),.i_addr(i_addr),
.i_wdata(i_wdata),.i_wr(i_wr),.i_rd(i_rd),.i_evt_low(i_evt_low),
.i_evt_mid(i_evt_mid),.i_evt_high(i_evt_high),.o_rdata(o_rdata),
.o_irq_pending(o_irq_pending));
mieg_core u_core(.i_clk(i_clk),.i_irq(o_irq_pending),.o_taken(taken));
task chk(input logic [7:0] s,e);
n_checks++;
if (s!==e) begin
fail_count++; $display("unexpected %0t seen %h expected %h",$time,s,e);
end
endtask
// Strobes stay up until the next task, so calls can run back to back
task wr(input logic [7:0] ad,d);
i_rd=0; i_wr=1; i_addr=ad; i_wdata=d; @(negedge i_clk);
endtask
task rd(input logic [7:0] ad,e);
i_wr=0; i_rd=1; i_addr=ad; @(negedge i_clk); chk(o_rdata,e);
endtask
task ev(input logic [19:0] v);
i_wr=0; i_rd=0; {i_evt_high,i_evt_mid,i_evt_low}=v; @(negedge i_clk);
{i_evt_high,i_evt_mid,i_evt_low}=0;
endtask
task ck(input logic e);
i_wr=0; i_rd=0; @(negedge i_clk); chk({7'h0,o_irq_pending},{7'h0,e});
endtask
task print_verdict;
$display("checks %0d mismatches %0d",n_checks,fail_count);
if (fail_count==0 && n_checks>0) $display("ALL TESTS PASSED");
else $display("TESTS FAILED");
$finish;
endtask
initial begin #100000; fail_count++; print_verdict; end
initial begin
repeat (16) @(negedge i_clk); i_resetn=1;
rd(8'hD9,0); rd(8'hDA,0); rd(8'hDB,0); ck(0);
wr(8'hD9,8'hFF); rd(8'hD9,8'h3F);
wr(8'hDB,8'hFF); rd(8'hDB,8'h3F);
wr(8'hDA,8'hA5); rd(8'hDA,8'hA5);
wr(8'h00,8'hFF); rd(8'h00,0);
$display("test registers done");
wr(8'hD9,8'h20); wr(8'hDA,0); wr(8'hDB,0);
ev(20'h1); ck(0);
ev(20'h20); ck(1); ck(1); chk({7'h0,taken},8'h01);
rd(8'hDC,8'hA1);
wr(8'hDC,8'h20); ck(0);
wr(8'hD9,8'h01); ck(1);
wr(8'hDC,8'h01); ck(0); wr(8'hD9,0);
$display("test fault done");
for (int k=0;k<5;k++) begin
a=(k>2)?8'hDB:8'hDA; m=mt[8*(4-k)+:8];
wr(a,m); ev((k>2)?{m[5:0],14'h0}:{6'h0,m,6'h0}); ck(1);
wr(a+8'h03,m); ck(0); wr(a,0);
end
$display("test sources done");
wr(8'hDB,8'h01); ev(20'h4000); ck(1);
i_resetn=0; ck(0); ck(0); i_resetn=1;
rd(8'hDB,0); rd(8'hDE,0); ck(0);
$display("test reset done");
print_verdict;
end
endmodule // mieg_gate_tb
bind mieg_gate mieg_sva u_sva(.i_clk(i_clk),.i_resetn(i_resetn),
.i_wr(i_wr),.i_rd(i_rd),.o_irq_pending(o_irq_pending),.i_addr(i_addr),
.i_wdata(i_wdata),.i_evt_mid(i_evt_mid),.o_rdata(o_rdata),
.i_evt_low(i_evt_low),.i_evt_high(i_evt_high));
`default_nettype wire
